// ### design/adc_ctrl.sv
// Converter control register, sample sequencer and result buffer
//
// Notes on behaviour
// - Converter runs only while the enable bit 15 is set.
// - Clearing enable wipes the result buffer; read results first.
// - Idle-stop bit 13 halts the converter while the device idles.
// - Format bits 9-8 justify the 10-bit result four ways.
// - Trigger code 111: internal counter ends sampling, starts conversion.
// - Trigger 110: charge time unit event ends sampling; 101-011 reserved.
// - Trigger code 010: third timer compare match ends sampling.
// - Auto-start bit 2 restarts sampling after each conversion.
// - Sample-enable bit 1 samples when 1, holds when 0.
// - Done bit 0 reads 1 once a conversion has completed.
//
// Bus side: zero wait states, so every access phase lasts one cycle.
// Read data is captured at the setup edge and stands until the next
// setup read; a read therefore shows the state one cycle before the
// access edge. Unmapped words read zero and raise pslverr.
//
// Analog side: sh_sample follows the sample state, conv_start pulses
// for one cycle as sampling ends, and the core answers with conv_done
// together with the raw code. The code is offset binary; the signed
// formats flip its top bit.
//
// Settings take effect at the access edge of the write, so one write
// may turn the converter on and open sampling together, and a write
// that turns it off freezes the sequencer on that very edge.
//
// The address map and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
module adc_ctrl
#(
   parameter logic [7:0] SAMPLE_CYCLES = adc_ctrl_pkg::SAMPLE_CYCLES_DEF
)
(
   input wire logic sys_clk, // System clock, 50 MHz
   input wire logic srst, // Synchronous reset, active high
   input wire logic psel, // APB select
   input wire logic penable, // APB access phase
   input wire logic pwrite, // APB write direction
   input wire logic [11:0] paddr, // APB byte address
   input wire logic [31:0] pwdata, // APB write data
   output logic [31:0] prdata, // APB read data
   output logic pready, // APB ready
   output logic pslverr, // APB error on unmapped address
   input wire logic idle_mode, // Device is in Idle mode
   input wire logic ext_trig_pin, // External trigger pin, async
   input wire logic third_timer_match, // Timer compare match pulse
   input wire logic charge_time_event, // Charge time unit event pulse
   input wire logic conv_done, // Core finished a conversion
   input wire logic [9:0] conv_data, // Core conversion code
   output logic converter_power, // Analog core powered
   output logic sh_sample, // Sample/hold in sampling
   output logic conv_start // One-cycle conversion start
);
   typedef struct packed
   {
      logic converter_enable;
      logic idle_stop;
      logic [1:0] result_format;
      logic [2:0] conversion_trigger_select;
      logic sample_auto_start;
      logic done;
      adc_ctrl_pkg::conv_state_t state;
      logic [15:0] result_buffer;
      logic conv_start;
      logic [31:0] rdata;
      logic pin_s1;
      logic pin_s2;
      logic pin_s3;
   } ctrl_state_t;

   ctrl_state_t q;
   ctrl_state_t d;

   logic ctrl_hit;
   logic result_hit;
   logic mapped;
   logic wr_ctrl;
   logic sw_samp;
   logic running;
   logic pin_edge;
   logic timer_expired;
   logic end_sample;
   logic [15:0] fmt_word;
   logic [15:0] ctrl_view;
   logic [31:0] rd_word;
   logic en_next;
   logic idle_next;
   logic start_ok;
   logic timer_run;
   logic open_sample;
   logic close_sample;
   logic latch_result;

   // Address decode for the two mapped words
   assign ctrl_hit = (paddr == adc_ctrl_pkg::CTRL_ADDR);
   assign result_hit = (paddr == adc_ctrl_pkg::RESULT_ADDR);
   assign mapped = ctrl_hit || result_hit;

   // Zero wait states keep the bus timing fixed
   assign pready = 1'b1;
   assign pslverr = psel && penable && !mapped;
   assign prdata = q.rdata;

   // Writes take effect at the access edge only
   assign wr_ctrl = psel && penable && pwrite && ctrl_hit;
   assign sw_samp = wr_ctrl && pwdata[adc_ctrl_pkg::SAMP_BIT];

   // Idle stop freezes the sequencer but keeps its settings
   assign running = q.converter_enable
      && !(q.idle_stop && idle_mode);

   // Settings as they stand after this edge. Gating the sequencer on
   // these rather than on the stored bits keeps a sample request that
   // comes in the same write as the enable from being lost
   assign en_next = wr_ctrl ? pwdata[adc_ctrl_pkg::EN_BIT]
      : q.converter_enable;
   assign idle_next = wr_ctrl ? pwdata[adc_ctrl_pkg::IDLE_BIT]
      : q.idle_stop;
   assign start_ok = en_next
      && !(idle_next && idle_mode);

   // Rising edge on the resynchronised pin; s1 feeds only s2
   assign pin_edge = q.pin_s2 && !q.pin_s3;

   // Control register as software sees it
   always_comb
   begin
      ctrl_view = adc_ctrl_pkg::CTRL_RESET;
      ctrl_view[adc_ctrl_pkg::EN_BIT] = q.converter_enable;
      ctrl_view[adc_ctrl_pkg::IDLE_BIT] = q.idle_stop;
      ctrl_view[adc_ctrl_pkg::FMT_MSB:adc_ctrl_pkg::FMT_LSB] =
         q.result_format;
      ctrl_view[adc_ctrl_pkg::TRIG_MSB:adc_ctrl_pkg::TRIG_LSB] =
         q.conversion_trigger_select;
      ctrl_view[adc_ctrl_pkg::AUTO_BIT] = q.sample_auto_start;
      ctrl_view[adc_ctrl_pkg::SAMP_BIT] =
         (q.state == adc_ctrl_pkg::ST_SAMPLE);
      ctrl_view[adc_ctrl_pkg::DONE_BIT] = q.done;
   end

   // Timer runs only through a sample phase that the counter will end;
   // any other phase holds it at zero so each phase starts afresh
   assign timer_run = running
      && (q.state == adc_ctrl_pkg::ST_SAMPLE)
      && (q.conversion_trigger_select == adc_ctrl_pkg::TRIG_AUTO);

   // Counter that times the sample phase in auto-convert mode
   sample_timer
   #(
      .CNT_W(adc_ctrl_pkg::SAMPLE_CNT_W),
      .CYCLES(SAMPLE_CYCLES)
   )
   u_timer
   (
      .sys_clk(sys_clk),
      .srst(srst),
      .count_en(timer_run),
      .expired(timer_expired)
   );

   // Justified form of the incoming conversion code
   result_formatter u_fmt
   (
      .raw(conv_data),
      .format(q.result_format),
      .word(fmt_word)
   );

   // Pick the event that closes the sample phase
   always_comb
   begin
      unique case (q.conversion_trigger_select)
         adc_ctrl_pkg::TRIG_AUTO:
         begin
            end_sample = timer_expired;
         end
         adc_ctrl_pkg::TRIG_CHARGE:
         begin
            end_sample = charge_time_event;
         end
         adc_ctrl_pkg::TRIG_THIRD_TIMER:
         begin
            end_sample = third_timer_match;
         end
         adc_ctrl_pkg::TRIG_PIN:
         begin
            end_sample = pin_edge;
         end
         adc_ctrl_pkg::TRIG_MANUAL:
         begin
            // Software ends sampling by writing sample-enable low
            end_sample = wr_ctrl
               && !pwdata[adc_ctrl_pkg::SAMP_BIT];
         end
         default:
         begin
            // Reserved codes never end sampling
            end_sample = 1'b0;
         end
      endcase
   end

   // Sequencer events, each true for at most one cycle
   assign open_sample = start_ok
      && (q.state == adc_ctrl_pkg::ST_HOLD)
      && (sw_samp || q.sample_auto_start);
   assign close_sample = start_ok
      && (q.state == adc_ctrl_pkg::ST_SAMPLE)
      && end_sample;
   assign latch_result = start_ok
      && (q.state == adc_ctrl_pkg::ST_CONVERT)
      && conv_done;

   // Read mux; unmapped words read as zero
   always_comb
   begin
      rd_word = 32'h0000_0000;
      if (ctrl_hit)
      begin
         rd_word = {16'h0000, ctrl_view};
      end
      else if (result_hit)
      begin
         rd_word = {16'h0000, q.result_buffer};
      end
   end

   // Next state of the whole block
   always_comb
   begin
      d = q;
      d.conv_start = 1'b0;
      d.pin_s1 = ext_trig_pin;
      d.pin_s2 = q.pin_s1;
      d.pin_s3 = q.pin_s2;

      // Read data is captured in the setup cycle, so it already stands
      // through the access phase with no wait state
      if (psel && !penable && !pwrite)
      begin
         d.rdata = rd_word;
      end

      // Software writes to the configuration fields
      if (wr_ctrl)
      begin
         d.converter_enable = pwdata[adc_ctrl_pkg::EN_BIT];
         d.idle_stop = pwdata[adc_ctrl_pkg::IDLE_BIT];
         d.result_format =
            pwdata[adc_ctrl_pkg::FMT_MSB:adc_ctrl_pkg::FMT_LSB];
         d.conversion_trigger_select =
            pwdata[adc_ctrl_pkg::TRIG_MSB:adc_ctrl_pkg::TRIG_LSB];
         d.sample_auto_start = pwdata[adc_ctrl_pkg::AUTO_BIT];
      end

      // Sequencer; steps only while the settings let it run
      if (start_ok)
      begin
         unique case (q.state)
            adc_ctrl_pkg::ST_HOLD:
            begin
               // Software or auto-start opens a sample phase
               if (open_sample)
               begin
                  d.state = adc_ctrl_pkg::ST_SAMPLE;
               end
            end
            adc_ctrl_pkg::ST_SAMPLE:
            begin
               if (close_sample)
               begin
                  d.state = adc_ctrl_pkg::ST_CONVERT;
                  d.conv_start = 1'b1;
               end
            end
            adc_ctrl_pkg::ST_CONVERT:
            begin
               // Completion latches result and sets done
               if (latch_result)
               begin
                  d.result_buffer = fmt_word;
                  // Auto-start resumes from hold next cycle
                  d.state = adc_ctrl_pkg::ST_HOLD;
               end
            end
            default:
            begin
               d.state = adc_ctrl_pkg::ST_HOLD;
            end
         endcase
      end

      // Done flag: hardware beats a software write in the same cycle,
      // so a completion can never be lost to a stale register write
      if (open_sample)
      begin
         d.done = 1'b0;
      end
      else if (latch_result)
      begin
         d.done = 1'b1;
      end
      else if (wr_ctrl)
      begin
         d.done = pwdata[adc_ctrl_pkg::DONE_BIT];
      end

      // Disabled converter forgets everything in flight; a write that
      // turns it on again may already open sampling in this cycle
      if (!q.converter_enable)
      begin
         d.result_buffer = adc_ctrl_pkg::RESULT_RESET;
         d.conv_start = 1'b0;
         if (!start_ok)
         begin
            d.state = adc_ctrl_pkg::ST_HOLD;
         end
      end
   end

   // Single register stage for all state
   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         q <= '0;
         q.state <= adc_ctrl_pkg::ST_HOLD;
      end
      else
      begin
         q <= d;
      end
   end

   // Analog side controls, all from flops so the core sees no glitches
   assign converter_power = q.converter_enable;

   // Sample/hold follows the state, one register after the deciding edge
   assign sh_sample = (q.state == adc_ctrl_pkg::ST_SAMPLE);

   // Single-cycle pulse; the core must catch it on that one edge
   assign conv_start = q.conv_start;
endmodule

// ### design/adc_ctrl_pkg.sv
// Constants and types shared by the converter control design
package adc_ctrl_pkg;
   // Register map, byte addresses on the APB side
   localparam int ADDR_W = 12;
   localparam logic [11:0] CTRL_ADDR = 12'h000;
   localparam logic [11:0] RESULT_ADDR = 12'h004;
   localparam int REG_W = 16;
   localparam int RES_W = 10;
   localparam logic [15:0] CTRL_RESET = 16'h0000;
   localparam logic [15:0] RESULT_RESET = 16'h0000;

   // Control register field positions
   localparam int EN_BIT = 15;
   localparam int IDLE_BIT = 13;
   localparam int FMT_LSB = 8;
   localparam int FMT_MSB = 9;
   localparam int TRIG_LSB = 5;
   localparam int TRIG_MSB = 7;
   localparam int AUTO_BIT = 2;
   localparam int SAMP_BIT = 1;
   localparam int DONE_BIT = 0;

   // Conversion trigger codes; 3, 4 and 5 are reserved
   localparam logic [2:0] TRIG_MANUAL = 3'h0;
   localparam logic [2:0] TRIG_PIN = 3'h1;
   localparam logic [2:0] TRIG_THIRD_TIMER = 3'h2;
   localparam logic [2:0] TRIG_CHARGE = 3'h6;
   localparam logic [2:0] TRIG_AUTO = 3'h7;

   // Result format codes
   localparam logic [1:0] FMT_UINT = 2'h0;
   localparam logic [1:0] FMT_SINT = 2'h1;
   localparam logic [1:0] FMT_UFRAC = 2'h2;
   localparam logic [1:0] FMT_SFRAC = 2'h3;

   // Sample time of the internal counter, in clock cycles
   localparam int SAMPLE_CNT_W = 8;
   localparam logic [7:0] SAMPLE_CYCLES_DEF = 8'h1F;

   typedef enum logic [1:0]
   {
      ST_HOLD = 2'b00,
      ST_SAMPLE = 2'b01,
      ST_CONVERT = 2'b10
   } conv_state_t;
endpackage

// ### design/result_formatter.sv
// Justifies a raw converter code into the 16-bit result word
`timescale 1ns/1ps
module result_formatter
(
   input wire logic [9:0] raw, // Raw converter code
   input wire logic [1:0] format, // Selected result format
   output logic [15:0] word // Justified result
);
   logic [9:0] signed_code;

   // Offset binary to two's complement by flipping the top bit
   assign signed_code = {~raw[9], raw[8:0]};

   // Select the justification
   always_comb
   begin
      unique case (format)
         adc_ctrl_pkg::FMT_SFRAC: word = {signed_code, 6'h00};
         adc_ctrl_pkg::FMT_UFRAC: word = {raw, 6'h00};
         adc_ctrl_pkg::FMT_SINT: word = {{6{signed_code[9]}}, signed_code};
         adc_ctrl_pkg::FMT_UINT: word = {6'h00, raw};
      endcase
   end
endmodule

// ### design/sample_timer.sv
// Counts the automatic sample time and flags when it has run out
`timescale 1ns/1ps
module sample_timer
#(
   parameter int CNT_W = adc_ctrl_pkg::SAMPLE_CNT_W,
   parameter logic [CNT_W-1:0] CYCLES = adc_ctrl_pkg::SAMPLE_CYCLES_DEF
)
(
   input wire logic sys_clk, // System clock
   input wire logic srst, // Synchronous reset
   input wire logic count_en, // High while auto sampling runs
   output logic expired // Sample time has elapsed
);
   typedef struct packed
   {
      logic [CNT_W-1:0] count;
   } timer_state_t;

   timer_state_t q;
   timer_state_t d;

   // Last count reached ends the sample phase
   assign expired = count_en && (q.count == CYCLES - 1'b1);

   // Restart from zero whenever sampling stops
   always_comb
   begin
      d = q;
      if (!count_en || expired)
      begin
         d.count = '0;
      end
      else
      begin
         d.count = q.count + 1'b1;
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         q <= '0;
      end
      else
      begin
         q <= d;
      end
   end
endmodule

// ### verif/adc_ctrl_checker.sv
// Port-level assertions for the converter control block
`timescale 1ns/1ps
module adc_ctrl_checker
(
   input wire logic sys_clk, // Clock
   input wire logic srst, // Reset
   input wire logic psel, // APB select
   input wire logic penable, // APB access
   input wire logic pwrite, // APB direction
   input wire logic [11:0] paddr, // APB address
   input wire logic [31:0] pwdata, // APB write data
   input wire logic [31:0] prdata, // APB read data
   input wire logic pready, // APB ready
   input wire logic pslverr, // APB error
   input wire logic converter_power, // Core power
   input wire logic sh_sample, // Sampling
   input wire logic conv_start // Start pulse
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (srst);
   // Access phase and map decode
   wire acc = psel && penable;
   wire hit = paddr == adc_ctrl_pkg::CTRL_ADDR ||
      paddr == adc_ctrl_pkg::RESULT_ADDR;
   wire wr_ctrl = acc && pwrite && paddr == adc_ctrl_pkg::CTRL_ADDR;

   a_power_follows: assert property (wr_ctrl |=>
      converter_power == $past(pwdata[15])) else $error("power bit lost");
   a_off_quiet: assert property (!converter_power [*2] |->
      !sh_sample && !conv_start) else $error("activity while off");
   a_sample_power: assert property (sh_sample |->
      converter_power || $past(converter_power)) else $error("unpowered");
   a_start_ends: assert property (conv_start |->
      !sh_sample && $past(sh_sample)) else $error("start not after sample");
   a_start_single: assert property (conv_start |=>
      !conv_start) else $error("start pulse too long");
   a_ready_high: assert property (acc |-> pready)
      else $error("no ready");
   a_err_unmapped: assert property (acc && !hit |-> pslverr)
      else $error("no error on unmapped");
   a_err_mapped: assert property (acc && hit |-> !pslverr)
      else $error("error on mapped");
   a_upper_zero: assert property (acc && !pwrite |->
      prdata[31:16] == 16'h0000) else $error("upper read bits set");
   c_start: cover property (conv_start);
   c_sample: cover property ($rose(sh_sample));
   c_err: cover property (acc && pslverr);
endmodule

bind adc_ctrl adc_ctrl_checker adc_ctrl_checker_i
(
   .sys_clk(sys_clk), .srst(srst), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .converter_power(converter_power),
   .sh_sample(sh_sample), .conv_start(conv_start)
);

// ### verif/conv_core_model.sv
// Behavioural model of the analog converter core
`timescale 1ns/1ps
module conv_core_model
(
   input wire logic sys_clk, // Clock
   input wire logic srst, // Reset
   input wire logic conv_start, // Start pulse
   input wire logic [3:0] lat, // Conversion time in cycles
   input wire logic [9:0] code, // Code to hand back
   output logic conv_done, // Done pulse
   output logic [9:0] conv_data // Code, valid with done only
);
   int cnt;
   initial
   begin
      conv_done = 1'b0;
      conv_data = 10'h000;
   end
   // Data is inverted outside the done cycle so stale reads show up
   always @(posedge sys_clk)
   begin
      conv_done <= 1'b0;
      conv_data <= ~code;
      if (srst)
         cnt <= 0;
      else if (conv_start)
         cnt <= int'(lat);
      else if (cnt == 1)
      begin
         cnt <= 0;
         conv_done <= 1'b1;
         conv_data <= code;
      end
      else if (cnt > 1)
         cnt <= cnt - 1;
   end
endmodule

// ### verif/adc_sample_convert_control_bench.sv
// Self-checking bench for the converter control block
`timescale 1ns/1ps
`define CHK(a, e) \
   begin \
      samples_checked++; \
      if ((a) !== (e)) \
      begin \
         error_cnt++; \
         $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); \
      end \
   end
module adc_sample_convert_control_bench;
   localparam logic [7:0] SCYC = 8'h04;
   localparam logic [11:0] CA = adc_ctrl_pkg::CTRL_ADDR;
   localparam logic [11:0] RA = adc_ctrl_pkg::RESULT_ADDR;
   logic sys_clk = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0;
   logic pwrite = 1'b0, idle_mode = 1'b0, ext_trig_pin = 1'b0;
   logic third_timer_match = 1'b0, charge_time_event = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic slv_err;
   logic pready, pslverr, conv_done, converter_power, sh_sample, conv_start;
   logic [9:0] conv_data, code = 10'h2C5;
   logic [3:0] lat = 4'h3;
   int error_cnt = 0, samples_checked = 0, samp_cnt = 0;

   always #10 sys_clk = ~sys_clk;
   // Sampling length seen at the pin
   always @(posedge sys_clk)
      if (sh_sample)
         samp_cnt++;

   adc_ctrl #(.SAMPLE_CYCLES(SCYC)) adc_ctrl_i
   (
      .sys_clk(sys_clk), .srst(srst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .idle_mode(idle_mode),
      .ext_trig_pin(ext_trig_pin), .third_timer_match(third_timer_match),
      .charge_time_event(charge_time_event), .conv_done(conv_done),
      .conv_data(conv_data), .converter_power(converter_power),
      .sh_sample(sh_sample), .conv_start(conv_start)
   );
   conv_core_model conv_core_model_i
   (
      .sys_clk(sys_clk), .srst(srst), .conv_start(conv_start), .lat(lat),
      .code(code), .conv_done(conv_done), .conv_data(conv_data)
   );

   task automatic end_of_test();
      if (error_cnt == 0 && samples_checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // One APB transfer; an idle edge first keeps strobes from doubling
   task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d);
      int n;
      @(posedge sys_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge sys_clk);
         n++;
      end
      while (pready !== 1'b1 && n < 50);
      rd = prdata;
      slv_err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 50)
      begin
         error_cnt++;
         end_of_test();
      end
   endtask

   task automatic wait_done();
      int n;
      n = 0;
      rd = 32'h0;
      while (rd[0] !== 1'b1 && n < 60)
      begin
         apb(1'b0, CA, 32'h0);
         n++;
      end
      if (n >= 60)
      begin
         error_cnt++;
         end_of_test();
      end
   endtask

   function automatic logic [31:0] cw(input logic [1:0] f,
      input logic [2:0] t, input logic a, input logic s);
      cw = {16'h0, 1'b1, 5'h0, f, t, 2'h0, a, s, 1'b0};
   endfunction

   // Signed forms flip the top bit of the offset-binary code
   function automatic logic [31:0] fexp(input logic [9:0] r,
      input logic [1:0] f);
      logic [9:0] s;
      s = {~r[9], r[8:0]};
      case (f)
         2'h0: fexp = {22'h0, r};
         2'h1: fexp = {16'h0, {6{s[9]}}, s};
         2'h2: fexp = {16'h0, r, 6'h0};
         default: fexp = {16'h0, s, 6'h0};
      endcase
   endfunction

   task automatic pulse(input logic [2:0] m);
      @(posedge sys_clk);
      ext_trig_pin <= m[0];
      third_timer_match <= m[1];
      charge_time_event <= m[2];
      @(posedge sys_clk);
      third_timer_match <= 1'b0;
      charge_time_event <= 1'b0;
      repeat (6) @(posedge sys_clk);
      ext_trig_pin <= 1'b0;
   endtask

   task automatic t_regs();
      apb(1'b0, CA, 32'h0);
      `CHK(rd, 32'h0)
      `CHK(slv_err, 1'b0)
      apb(1'b1, CA, 32'h5C18);
      apb(1'b0, CA, 32'h0);
      `CHK(rd, 32'h0)
      apb(1'b0, 12'h008, 32'h0);
      `CHK(rd, 32'h0)
      `CHK(slv_err, 1'b1)
   endtask

   // Counter trigger in every format, codes of both signs
   task automatic t_formats();
      for (int f = 0; f < 4; f++)
      begin
         code <= f[1] ? 10'h13A : 10'h2C5;
         samp_cnt = 0;
         apb(1'b1, CA, cw(f[1:0], 3'h7, 1'b0, 1'b1));
         wait_done();
         `CHK(samp_cnt, int'(SCYC))
         apb(1'b0, RA, 32'h0);
         `CHK(rd, fexp(code, f[1:0]))
      end
   endtask

   // Manual, pin, timer and charge triggers ignore the other sources; reserved code never ends
   task automatic t_trig();
      logic [2:0] tc [5] = '{3'h0, 3'h1, 3'h2, 3'h6, 3'h5};
      logic [2:0] rm [5] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h0};
      for (int i = 0; i < 5; i++)
      begin
         lat <= i[0] ? 4'h1 : 4'hC;
         apb(1'b1, CA, cw(2'h0, tc[i], 1'b0, 1'b1));
         apb(1'b0, CA, 32'h0);
         `CHK(rd[1:0], 2'b10)
         pulse(3'h7 & ~rm[i]);
         `CHK(sh_sample, 1'b1)
         if (tc[i] == 3'h5)
            apb(1'b1, CA, 32'h0);
         else
         begin
            if (tc[i] == 3'h0)
               apb(1'b1, CA, cw(2'h0, 3'h0, 1'b0, 1'b0));
            pulse(rm[i]);
            wait_done();
            `CHK(rd[1], 1'b0)
         end
      end
   endtask

   task automatic t_idle();
      idle_mode <= 1'b1;
      apb(1'b1, CA, cw(2'h0, 3'h0, 1'b0, 1'b1) | 32'h2000);
      repeat (3) @(posedge sys_clk);
      `CHK(sh_sample, 1'b0)
      apb(1'b1, CA, cw(2'h0, 3'h0, 1'b0, 1'b1));
      repeat (3) @(posedge sys_clk);
      `CHK(sh_sample, 1'b1)
      apb(1'b1, CA, 32'h0);
      idle_mode <= 1'b0;
   endtask

   // Auto restart, then disabling wipes the result
   task automatic t_auto_off();
      int n;
      apb(1'b1, CA, cw(2'h2, 3'h7, 1'b1, 1'b1));
      n = 0;
      while (conv_done !== 1'b1 && n < 100)
      begin
         @(posedge sys_clk);
         n++;
      end
      if (n >= 100)
      begin
         error_cnt++;
         end_of_test();
      end
      repeat (3) @(posedge sys_clk);
      `CHK(sh_sample, 1'b1)
      apb(1'b0, RA, 32'h0);
      `CHK(rd, fexp(code, 2'h2))
      apb(1'b1, CA, 32'h0);
      apb(1'b0, RA, 32'h0);
      `CHK(rd, 32'h0)
      `CHK(converter_power, 1'b0)
   endtask

   initial
   begin
      repeat (5) @(posedge sys_clk);
      srst <= 1'b0;
      t_regs();
      t_formats();
      t_trig();
      t_idle();
      t_auto_off();
      end_of_test();
   end
endmodule
